// ---- shared/thermal_pkg.sv ----
// shared constants, register map and carrier types of the thermal alarm block
package thermal_pkg;
  // register addresses on the register port
  localparam logic [7:0] ADDR_CFG1 = 8'h41;
  localparam logic [7:0] ADDR_CFG2 = 8'h42;
  localparam logic [7:0] ADDR_CFG3 = 8'h43;
  localparam logic [7:0] ADDR_STAT1 = 8'h44;
  localparam logic [7:0] ADDR_STAT2 = 8'h45;
  localparam logic [7:0] ADDR_STAT3 = 8'h46;
  localparam logic [7:0] ADDR_ALERT_LOCAL = 8'h17;
  localparam logic [7:0] ADDR_ALERT_REM = 8'h10; // remote n at this base plus n
  localparam logic [7:0] ADDR_OVER_REM = 8'h20;  // remote n at this base plus n
  // field positions
  localparam int CFG1_STOP_BIT = 7;
  localparam int CFG1_SRC_BIT = 3;
  localparam int STAT1_LOCAL_BIT = 6;
  // writable and readable bits of each register
  localparam logic [7:0] CFG1_MASK = 8'h98;
  localparam logic [7:0] CFG2_MASK = 8'h7F;
  localparam logic [7:0] CFG3_MASK = 8'h39;
  localparam logic [7:0] STAT1_MASK = 8'h7F;
  localparam logic [7:0] STAT2_MASK = 8'h39;
  localparam logic [7:0] STAT3_MASK = 8'h7E;
  // channels that own an overtemperature limit (index 0 is local)
  localparam logic [6:0] OVER_CHANS = 7'h72;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [6:0][7:0] ALERT_RST = {8'h64, 8'h64, 8'h64, 8'h64, 8'h7F, 8'h6E, 8'h5A};
  localparam logic [6:0][7:0] OVER_RST = {8'h5A, 8'h5A, 8'h5A, 8'hFF, 8'hFF, 8'h6E, 8'hFF};
  // temperature hysteresis in degrees
  localparam logic [8:0] HYST_DEG = 9'h004;
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int SLOT_MS = 125;
  localparam int SRC_EXTRA_MS = 125;
  localparam int SLOT_CYCLES = SLOT_MS * (CLK_HZ / 1000);
  localparam int SRC_EXTRA_CYCLES = SRC_EXTRA_MS * (CLK_HZ / 1000);
  localparam logic [2:0] LAST_CHAN = 3'h6;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } reg_rsp_s;

  typedef enum logic {SEQ_STOP, SEQ_CONV} seq_state_e;
endpackage : thermal_pkg

// ---- hw/chan_eval.sv ----
// per-channel limit comparison and overtemperature hold with hysteresis
`timescale 1ns/1ps
module chan_eval
  import thermal_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic eval,
  input wire logic [7:0] temp,
  input wire logic [7:0] alert_limit,
  input wire logic [7:0] over_limit,
  output logic alert_hit,
  output logic over_hit,
  output logic over_active
);
  logic released;

  // compare only at the end of this channel's conversion
  assign alert_hit = eval && (temp > alert_limit);
  assign over_hit = eval && (temp > over_limit);
  // released once temperature sits at least the hysteresis below the limit
  assign released = ({1'b0, temp} + HYST_DEG) <= {1'b0, over_limit};

  // overtemperature condition held until released
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      over_active <= 1'b0;
    end else if (over_hit) begin
      over_active <= 1'b1;
    end else if (eval && released) begin
      over_active <= 1'b0;
    end
  end

  a_hyst_hold: assert property (@(posedge clk) disable iff (!rstn)
    over_active && eval && !released |=> over_active)
    else $error("overtemperature released inside hysteresis band");
endmodule : chan_eval

// ---- hw/thermal_alarm_status_mask.sv ----
// alarm status, masking and channel sequencing of the temperature monitor
// Functional notes
// - overheat masks for channels 1,4,5,6 in config 3
// - overheat masks reset unmasked, reserved bits read zero
// - local over warning limit sets status bit 6
// - remote channel n over limit sets bit n-1
// - status one resets to zero, bit 7 zero
// - resistance cancellation only channel 1, config1 bit 3
// - cancellation lengthens channel 1 slot by 125 ms
// - faulty diode flagged in status and skipped
// - mask blocks warning and overheat, diode faults too
// - warning masks remote 1-6 bits 0-5, local 6
// - overheat status clears on status 2 read only
// - overheat removed only at or below limit minus 4 degrees
`timescale 1ns/1ps
module thermal_alarm_status_mask #(
  parameter int unsigned BASE_SLOT_CYCLES = thermal_pkg::SLOT_CYCLES,
  parameter int unsigned SRC_EXTRA_CYC = thermal_pkg::SRC_EXTRA_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire thermal_pkg::reg_req_s REG_REQ,
  output thermal_pkg::reg_rsp_s REG_RSP,
  input wire logic [7:0] TEMP_IN,
  input wire logic [6:1] DIODE_FAULT_IN,
  output logic [2:0] CONV_CHAN,
  output logic SRC_ACTIVE,
  output logic WARN_OUT_O,
  output logic WARN_OUT_OE,
  output logic OVERHEAT_OUT_O,
  output logic OVERHEAT_OUT_OE
);
  import thermal_pkg::*;

  // ****************************************
  // registers and decode
  // ****************************************
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [7:0] overheat_mask_config;
  logic [7:0] warning_status_one;
  logic [7:0] status2;
  logic [7:0] status3;
  logic [6:0][7:0] alert_lim;
  logic [6:0][7:0] over_lim;
  logic [7:0] next_rdata;
  logic rd1;
  logic rd2;

  assign rd1 = REG_REQ.rd && (REG_REQ.addr == ADDR_STAT1);
  assign rd2 = REG_REQ.rd && (REG_REQ.addr == ADDR_STAT2);

  // configuration writes, reserved bits never stored
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg1 <= CFG_RST;
      cfg2 <= CFG_RST;
      overheat_mask_config <= CFG_RST;
    end else if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        ADDR_CFG1: cfg1 <= REG_REQ.wdata & CFG1_MASK;
        ADDR_CFG2: cfg2 <= REG_REQ.wdata & CFG2_MASK;
        ADDR_CFG3: overheat_mask_config <= REG_REQ.wdata & CFG3_MASK;
        default: ;
      endcase
    end
  end

  // limit writes: local warning, remote warning, remote overheat
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      alert_lim <= ALERT_RST;
      over_lim <= OVER_RST;
    end else if (REG_REQ.wr) begin
      if (REG_REQ.addr == ADDR_ALERT_LOCAL) begin
        alert_lim[0] <= REG_REQ.wdata;
      end
      for (int k = 1; k < 7; k++) begin
        if (REG_REQ.addr == ADDR_ALERT_REM + 8'(k)) begin
          alert_lim[k] <= REG_REQ.wdata;
        end
        if (OVER_CHANS[k] && REG_REQ.addr == ADDR_OVER_REM + 8'(k)) begin
          over_lim[k] <= REG_REQ.wdata;
        end
      end
    end
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (REG_REQ.addr)
      ADDR_CFG1: next_rdata = cfg1;
      ADDR_CFG2: next_rdata = cfg2;
      ADDR_CFG3: next_rdata = overheat_mask_config;
      ADDR_STAT1: next_rdata = warning_status_one;
      ADDR_STAT2: next_rdata = status2;
      ADDR_STAT3: next_rdata = status3;
      ADDR_ALERT_LOCAL: next_rdata = alert_lim[0];
      default: begin
        for (int k = 1; k < 7; k++) begin
          if (REG_REQ.addr == ADDR_ALERT_REM + 8'(k)) begin
            next_rdata = alert_lim[k];
          end
          if (OVER_CHANS[k] && REG_REQ.addr == ADDR_OVER_REM + 8'(k)) begin
            next_rdata = over_lim[k];
          end
        end
      end
    endcase
  end

  // read answer one cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RSP <= '0;
    end else begin
      REG_RSP.valid <= REG_REQ.rd;
      REG_RSP.rdata <= REG_REQ.rd ? next_rdata : 8'h00;
    end
  end

  // ****************************************
  // measurement sequence
  // ****************************************
  seq_state_e state;
  logic [31:0] slot_cnt;
  logic [31:0] slot_len;
  logic eval;
  logic [2:0] next_chan;
  logic [6:0] eval_vec;

  // channel 1 slot is longer while cancellation is on
  assign slot_len = (CONV_CHAN == 3'h1 && cfg1[CFG1_SRC_BIT]) ?
                    32'(BASE_SLOT_CYCLES + SRC_EXTRA_CYC) : 32'(BASE_SLOT_CYCLES);
  // at-or-past compare: clearing cancellation late in a long slot must not hang the count
  assign eval = (state == SEQ_CONV) && (slot_cnt >= slot_len - 32'h0000_0001);
  assign eval_vec = eval ? 7'(8'h01 << CONV_CHAN) : 7'h00;

  // next channel in order, passing over faulty diodes
  always_comb begin
    logic [2:0] cand;
    logic found;
    cand = CONV_CHAN;
    found = 1'b0;
    next_chan = 3'h0;
    for (int i = 0; i < 7; i++) begin
      cand = (cand == LAST_CHAN) ? 3'h0 : cand + 3'h1;
      if (!found && !status3[cand]) begin
        next_chan = cand;
        found = 1'b1;
      end
    end
  end

  // slot counter and channel pointer, stop bit halts conversions
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= SEQ_CONV;
      slot_cnt <= 32'h0000_0000;
      CONV_CHAN <= 3'h0;
    end else begin
      case (state)
        SEQ_CONV: begin
          if (cfg1[CFG1_STOP_BIT]) begin
            state <= SEQ_STOP;
            slot_cnt <= 32'h0000_0000;
          end else if (eval) begin
            slot_cnt <= 32'h0000_0000;
            CONV_CHAN <= next_chan;
          end else begin
            slot_cnt <= slot_cnt + 32'h0000_0001;
          end
        end
        SEQ_STOP: begin
          if (!cfg1[CFG1_STOP_BIT]) begin
            state <= SEQ_CONV;
            CONV_CHAN <= 3'h0;
          end
        end
        default: state <= SEQ_STOP;
      endcase
    end
  end

  // front end told to cancel series resistance on channel 1 only
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SRC_ACTIVE <= 1'b0;
    end else begin
      SRC_ACTIVE <= (state == SEQ_CONV) && (CONV_CHAN == 3'h1) && cfg1[CFG1_SRC_BIT];
    end
  end

  // ****************************************
  // channel evaluation and status
  // ****************************************
  logic [6:0] alert_hit;
  logic [6:0] over_hit;
  logic [6:0] over_active;

  for (genvar g = 0; g < 7; g++) begin : g_chan
    chan_eval u_eval (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .eval(eval_vec[g]),
      .temp(TEMP_IN),
      .alert_limit(alert_lim[g]),
      .over_limit(over_lim[g]),
      .alert_hit(alert_hit[g]),
      .over_hit(over_hit[g]),
      .over_active(over_active[g])
    );
  end

  // warning status: sticky, cleared by reading, a new hit wins over the clear
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      warning_status_one <= STAT_RST;
    end else begin
      warning_status_one <= ((rd1 ? 8'h00 : warning_status_one)
                             | {1'b0, alert_hit[0], alert_hit[6:1]}) & STAT1_MASK;
    end
  end

  // overheat status: cleared only by reading status 2
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      status2 <= STAT_RST;
    end else begin
      status2 <= ((rd2 ? 8'h00 : status2) | {2'b00, over_hit[6:1]}) & STAT2_MASK;
    end
  end

  // diode fault flags follow the open or shorted detectors
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      status3 <= STAT_RST;
    end else begin
      status3 <= {1'b0, DIODE_FAULT_IN, 1'b0} & STAT3_MASK;
    end
  end

  // ****************************************
  // open-drain alarm outputs
  // ****************************************
  logic warn_req;
  logic over_req;

  // masked channels never drive either output, faults included
  assign warn_req = |(warning_status_one[6:0] & ~cfg2[6:0])
                  | |(status3[6:1] & ~cfg2[5:0]);
  // held by the hysteresis state, so a status read does not release it
  assign over_req = |((over_active[6:1] | status3[6:1]) & ~overheat_mask_config[5:0]
                      & OVER_CHANS[6:1]);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WARN_OUT_O <= 1'b0;
      WARN_OUT_OE <= 1'b0;
      OVERHEAT_OUT_O <= 1'b0;
      OVERHEAT_OUT_OE <= 1'b0;
    end else begin
      WARN_OUT_O <= 1'b0; // pulls low when enabled
      WARN_OUT_OE <= warn_req;
      OVERHEAT_OUT_O <= 1'b0;
      OVERHEAT_OUT_OE <= over_req;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  logic [31:0] len_cnt;
  logic [7:0] prev_status2;
  logic prev_rd2;
  logic [6:0] prev_fault;

  // helper history for the checks
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      len_cnt <= 32'h0000_0000;
      prev_status2 <= STAT_RST;
      prev_rd2 <= 1'b0;
      prev_fault <= 7'h00;
    end else begin
      len_cnt <= (eval || state != SEQ_CONV) ? 32'h0000_0000 : len_cnt + 32'h0000_0001;
      prev_status2 <= status2;
      prev_rd2 <= rd2;
      prev_fault <= status3[6:0];
    end
  end

  sequence s_ch1_src_end;
    eval && CONV_CHAN == 3'h1 && cfg1[CFG1_SRC_BIT];
  endsequence

  sequence s_all_over_masked;
    (overheat_mask_config[5:3] == 3'h7 && overheat_mask_config[0])[*2];
  endsequence

  a_reserved_zero: assert property (overheat_mask_config[7:6] == 2'h0
    && overheat_mask_config[2:1] == 2'h0 && warning_status_one[7] == 1'b0)
    else $error("reserved bit read as one");
  a_local_set: assert property (eval && CONV_CHAN == 3'h0 && TEMP_IN > alert_lim[0]
    |=> warning_status_one[STAT1_LOCAL_BIT])
    else $error("local warning bit not set");
  a_remote_set: assert property (eval && CONV_CHAN != 3'h0 && TEMP_IN > alert_lim[CONV_CHAN]
    |=> warning_status_one[$past(CONV_CHAN) - 3'h1])
    else $error("remote warning bit not set");
  a_stat_only_eval: assert property (!eval |=> $stable(warning_status_one) || $past(rd1))
    else $error("warning status changed outside a conversion end");
  a_src_ch1: assert property (SRC_ACTIVE |-> $past(CONV_CHAN) == 3'h1
    && $past(cfg1[CFG1_SRC_BIT]))
    else $error("cancellation active outside channel 1");
  a_slot_long: assert property (s_ch1_src_end
    |-> len_cnt == 32'(BASE_SLOT_CYCLES + SRC_EXTRA_CYC - 1))
    else $error("channel 1 slot length wrong with cancellation");
  a_fault_skip: assert property (eval |=> CONV_CHAN == 3'h0 || !prev_fault[CONV_CHAN])
    else $error("faulty channel entered the sequence");
  a_over_masked: assert property (s_all_over_masked |-> !OVERHEAT_OUT_OE)
    else $error("masked channel drove overheat output");
  a_warn_masked: assert property (cfg2[6:0] == 7'h7F ##1 cfg2[6:0] == 7'h7F
    |-> !WARN_OUT_OE)
    else $error("masked channel drove warning output");
  a_over_sticky: assert property (!prev_rd2 |-> (status2 & prev_status2) == prev_status2)
    else $error("overheat status cleared without a read");
endmodule : thermal_alarm_status_mask

// ---- dv/diode_model.sv ----
// diode and local sensor model feeding results and fault levels to the block
`timescale 1ns/1ps
module diode_model (
  input wire logic [2:0] chan,
  input wire logic [6:0][7:0] temp_tab,
  input wire logic [6:1] open_set,
  output logic [7:0] temp_out,
  output logic [6:1] fault_out
);
  // result of the channel being converted, taken by the block at slot end
  assign temp_out = temp_tab[chan];
  // open or supply-tied diodes show a steady fault level
  assign fault_out = open_set;
endmodule : diode_model

// ---- dv/thermal_alarm_status_mask_tb.sv ----
// self-checking bench of the alarm status and mask block
`timescale 1ns/1ps
module thermal_alarm_status_mask_tb;
  import thermal_pkg::*;
  localparam int BASE = 20;
  localparam int EXTRA = 10;
  localparam logic [3:0][2:0] OV_BIT = {3'h5, 3'h4, 3'h3, 3'h0};
  logic clk;
  logic rstn;
  reg_req_s req;
  reg_rsp_s rsp;
  logic [7:0] temp;
  logic [6:1] fault;
  logic [2:0] chan;
  logic src;
  logic warn_o;
  logic warn_oe;
  logic over_o;
  logic over_oe;
  logic [6:0][7:0] temp_tab;
  logic [6:1] open_set;
  logic [6:0] seen;
  int failures;
  int checks;

  thermal_alarm_status_mask #(.BASE_SLOT_CYCLES(BASE), .SRC_EXTRA_CYC(EXTRA)) dut (
    .CORE_CLK(clk), .RSTN(rstn), .REG_REQ(req), .REG_RSP(rsp), .TEMP_IN(temp),
    .DIODE_FAULT_IN(fault), .CONV_CHAN(chan), .SRC_ACTIVE(src), .WARN_OUT_O(warn_o),
    .WARN_OUT_OE(warn_oe), .OVERHEAT_OUT_O(over_o), .OVERHEAT_OUT_OE(over_oe));
  diode_model partner (.chan(chan), .temp_tab(temp_tab), .open_set(open_set),
    .temp_out(temp), .fault_out(fault));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ***************************************
  // shared tasks
  // ***************************************
  // ***************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp_v);
    checks++;
    if (got !== exp_v) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp_v);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // read answer stands for the one cycle after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp_v, input logic [7:0] msk);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk({7'h00, rsp.valid}, 8'h01);
    chk(rsp.rdata & msk, exp_v & msk);
  endtask : rd

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : gap

  // bounded wait for a channel, noting every channel passed on the way
  task automatic wait_chan(input logic [2:0] c);
    int n;
    n = 0;
    gap(1);
    while (chan !== c && n < 1000) begin
      seen[chan] = 1'b1;
      gap(1);
      n++;
    end
    chk({7'h00, chan === c}, 8'h01);
  endtask : wait_chan

  // from channel 1 round to channel 0 twice, so every channel has converted with the present inputs
  task automatic sweep();
    wait_chan(3'h1);
    seen = '0;
    wait_chan(3'h0);
    wait_chan(3'h1);
    wait_chan(3'h0);
    gap(3);
  endtask : sweep

  task automatic slot_len(input logic [7:0] cfg, input int exp_len, input logic exp_src);
    int n;
    logic s;
    wait_chan(3'h2);
    wr(ADDR_CFG1, cfg);
    wait_chan(3'h1);
    n = 0;
    s = 1'b0;
    while (chan === 3'h1 && n < 1000) begin
      if (n == 2) begin
        s = src;
      end
      gap(1);
      n++;
    end
    chk(8'(n), 8'(exp_len));
    chk({7'h00, s}, {7'h00, exp_src});
  endtask : slot_len

  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_reset();
    chk({6'h00, warn_oe, over_oe}, 8'h00);
    chk({6'h00, warn_o, over_o}, 8'h00);
    rd(ADDR_CFG3, 8'h00, 8'hFF);
    rd(ADDR_STAT1, 8'h00, 8'hFF);
    rd(ADDR_CFG2, 8'h00, 8'hFF);
    $display("test reset done");
  endtask : t_reset

  task automatic t_status();
    @(posedge clk);
    temp_tab <= {7{8'h80}};
    sweep();
    chk({7'h00, warn_oe}, 8'h01);
    rd(ADDR_STAT1, 8'h7F, 8'hFF);
    rd(ADDR_STAT2, 8'h39, 8'hFF);
    chk({7'h00, over_oe}, 8'h01);
    chk({7'h00, warn_oe}, 8'h00);
    $display("test status done");
  endtask : t_status

  task automatic t_mask();
    sweep();
    wr(ADDR_CFG2, 8'hFF);
    wr(ADDR_CFG3, 8'hFF);
    rd(ADDR_CFG2, 8'h7F, 8'hFF);
    rd(ADDR_CFG3, 8'h39, 8'hFF);
    gap(3);
    chk({6'h00, warn_oe, over_oe}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CFG2, 8'h7F ^ (8'h01 << i));
      gap(3);
      chk({7'h00, warn_oe}, 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG3, 8'h39 ^ (8'h01 << OV_BIT[i]));
      gap(3);
      chk({7'h00, over_oe}, 8'h01);
    end
    wr(ADDR_CFG2, 8'h00);
    wr(ADDR_CFG3, 8'h00);
    $display("test mask done");
  endtask : t_mask

  // local one above limit, remote 2 equal to limit, remote 1 inside hysteresis band
  task automatic t_hyst();
    @(posedge clk);
    temp_tab <= {8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h6B, 8'h5B};
    rd(ADDR_STAT1, 8'h7F, 8'hFF);
    sweep();
    chk({7'h00, over_oe}, 8'h01);
    rd(ADDR_STAT1, 8'h40, 8'hFF);
    @(posedge clk);
    temp_tab <= {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6A, 8'h00};
    sweep();
    chk({7'h00, over_oe}, 8'h00);
    $display("test hysteresis done");
  endtask : t_hyst

  task automatic t_src();
    slot_len(8'h08, BASE + EXTRA, 1'b1);
    slot_len(8'h00, BASE, 1'b0);
    $display("test cancellation done");
  endtask : t_src

  // stop bit freezes the channel pointer, clearing it restarts at the local channel
  task automatic t_stop();
    logic [2:0] c;
    wr(ADDR_CFG1, 8'h80);
    gap(2);
    c = chan;
    gap(3 * BASE);
    chk({5'h00, chan}, {5'h00, c});
    wr(ADDR_CFG1, 8'h00);
    gap(2);
    chk({5'h00, chan}, 8'h00);
    $display("test stop done");
  endtask : t_stop

  // channels 3 and 4 unconnected
  task automatic t_fault();
    @(posedge clk);
    open_set <= 6'b00_1100;
    gap(2);
    sweep();
    rd(ADDR_STAT1, 8'h00, 8'hFF);
    chk({1'b0, seen}, 8'h67);
    rd(ADDR_STAT3, 8'h18, 8'hFF);
    chk({7'h00, warn_oe}, 8'h01);
    chk({7'h00, over_oe}, 8'h01);
    wr(ADDR_CFG2, 8'h0C);
    wr(ADDR_CFG3, 8'h08);
    gap(3);
    chk({6'h00, warn_oe, over_oe}, 8'h00);
    $display("test diode fault done");
  endtask : t_fault

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    rstn = 1'b0;
    req = '0;
    temp_tab = '0;
    open_set = '0;
    seen = '0;
    failures = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    gap(1);
    t_reset();
    t_status();
    t_mask();
    t_hyst();
    t_src();
    t_stop();
    t_fault();
    end_of_test();
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : thermal_alarm_status_mask_tb
